// ---- hdl/processor_error_status_unit.sv ----
// Purpose: records checks and exceptions in the status word, picks the class interrupt
// Assumes: sequencer presents one-cycle event pulses; storage answers reads in one cycle
// Notes: block save is requested from the sequencer; this unit supplies the address to save
module processor_error_status_unit
    import err_status_pkg::*;
(
    input wire logic clock, // processor clock
    input wire logic arst_n, // async reset, active low
    input wire logic exec_valid, // instruction being decoded this cycle
    input wire logic [4:0] opcode, // op field
    input wire logic [4:0] func, // function field
    input wire logic privileged, // decoded instruction is privileged
    input wire logic [15:0] instr_addr, // address of current instruction
    input wire logic [15:0] storage_pointer_reg, // storage address register
    input wire logic [1:0] active_level, // current priority level
    input wire logic level_active, // some level is active
    input wire logic misalign_evt, // alignment violation pulse
    input wire logic bad_addr_evt, // address beyond storage pulse
    input wire logic stack_evt, // stack exception pulse
    input wire logic parity_evt, // storage read parity pulse
    input wire logic ctrl_fault_evt, // processor control malfunction pulse
    input wire logic io_fault_evt, // I/O interface hardware error pulse
    input wire logic io_seq_evt, // an I/O interface sequence occurred
    input wire logic io_seq_kind, // 0 program-issued transfer, 1 interrupt/cycle steal
    input wire logic autoload_evt, // automatic initial program load pulse
    input wire logic power_warn, // power or thermal warning pin
    input wire logic copy_status_and_clear_instr, // store status word pulse
    input wire logic [15:0] copy_addr, // target of that store
    input wire logic load_level_block_instr, // load level block pulse
    input wire logic [15:0] block_addr, // storage address of block
    input wire logic [1:0] block_level, // selected level
    input wire logic mem_ready, // storage accepts the request
    input wire logic [15:0] mem_rdata, // storage read data, valid cycle after read
    output logic mem_req, // storage request
    output logic mem_we, // storage write
    output logic [15:0] mem_addr, // storage address
    output logic [15:0] mem_wdata, // storage write data
    output logic [15:0] processor_error_status, // status word
    output logic [3:0] class_irq, // one-hot class interrupt pulse
    output logic [15:0] saved_ip, // address to save in the level block
    output logic save_block, // request the sequencer to save the block
    output logic io_reset, // channel and device reset pulse
    output logic busy, // block load or status copy in progress
    output logic [15:0] sel_level_lsr, // level state of the current priority level (active_level)
    output logic [15:0] sel_level_ip // saved address, the same value as saved_ip
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_COPY = 4'b0010,
        ST_READ = 4'b0100,
        ST_WAIT = 4'b1000
    } state_e;

    state_e state_reg, state_next;
    logic [15:0] status_reg, status_next;
    logic [3:0] class_reg, class_next;
    logic [15:0] saved_reg, saved_next;
    logic save_reg, save_next;
    logic io_reset_reg, io_reset_next;
    logic [15:0] copy_addr_reg, copy_addr_next;
    logic [15:0] base_reg, base_next;
    logic [1:0] level_reg, level_next;
    logic [3:0] idx_reg, idx_next;
    logic [15:0] last_io_ip_reg, last_io_ip_next;
    logic pw_meta_reg, pw_sync_reg;
    logic illegal, reserved, supv, smask;
    logic r7_wr;
    logic [15:0] lsr_active, r7_unused;
    logic ext_wr;
    lsb_bus_if lb();

    opcode_checker u_opcode (
        .opcode(opcode),
        .func(func),
        .supv(supv),
        .illegal(illegal),
        .reserved(reserved)
    );

    level_block_store u_blocks (
        .clock(clock),
        .arst_n(arst_n),
        .bus(lb),
        .sel_level(level_reg),
        .r7_wr(r7_wr),
        .r7_level(active_level),
        .r7_data(storage_pointer_reg),
        .rd_level(active_level),
        .ip_out(),
        .lsr_out(lsr_active),
        .r7_out(r7_unused)
    );

    assign supv = lsr_active[pos(LSR_SUPV)];
    assign smask = lsr_active[pos(LSR_SMASK)];

    // words arrive one cycle after each read request
    assign lb.wr = ext_wr;
    assign lb.idx = idx_reg;
    assign lb.data = mem_rdata;

    // power warning is asynchronous to the clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pw_meta_reg <= 1'b0;
            pw_sync_reg <= 1'b0;
        end else begin
            pw_meta_reg <= power_warn;
            pw_sync_reg <= pw_meta_reg;
        end
    end

    logic pgm_evt, soft_evt, mchk_evt, pwr_evt, ctrl_evt;
    always_comb begin
        ctrl_evt = ctrl_fault_evt || (exec_valid && !level_active);
        pgm_evt = misalign_evt || bad_addr_evt || (exec_valid && ((privileged && !supv) || illegal));
        soft_evt = stack_evt || (exec_valid && reserved);
        mchk_evt = parity_evt || ctrl_evt || io_fault_evt;
        pwr_evt = pw_sync_reg && smask && !status_reg[pos(BIT_PWR)];
    end

    // status word, class selection and saved address
    always_comb begin
        status_next = status_reg;
        if (state_reg == ST_COPY && mem_ready) status_next = status_reg & ~STATUS_EVENT_BITS;
        if (misalign_evt) status_next[pos(BIT_SPEC)] = 1'b1;
        if (bad_addr_evt) status_next[pos(BIT_ADDR)] = 1'b1;
        if (exec_valid && privileged && !supv) status_next[pos(BIT_PRIV)] = 1'b1;
        if (exec_valid && (illegal || reserved)) status_next[pos(BIT_FUNC)] = 1'b1;
        if (stack_evt) status_next[pos(BIT_STACK)] = 1'b1;
        if (parity_evt) status_next[pos(BIT_PARITY)] = 1'b1;
        if (ctrl_evt) status_next[pos(BIT_CTRL)] = 1'b1;
        if (io_fault_evt) status_next[pos(BIT_IOCHK)] = 1'b1;
        if (io_seq_evt) status_next[pos(BIT_SEQ)] = io_seq_kind;
        if (autoload_evt) status_next[pos(BIT_AUTOLOAD)] = 1'b1;
        if (pw_sync_reg) status_next[pos(BIT_PWR)] = 1'b1;
        status_next = status_next & STATUS_USED;

        // priority: machine, program, soft, power; status bits 12/13 raise none
        class_next = CLS_NONE;
        if (mchk_evt) class_next = CLS_MACHINE;
        else if (pgm_evt) class_next = CLS_PROGRAM;
        else if (soft_evt) class_next = CLS_SOFT;
        else if (pwr_evt) class_next = CLS_POWER;
        save_next = (class_next != CLS_NONE);
        // failing address kept; I/O check from a program transfer names that instruction
        saved_next = saved_reg;
        if (io_fault_evt && !status_reg[pos(BIT_SEQ)]) saved_next = last_io_ip_reg;
        else if (save_next) saved_next = instr_addr;
        last_io_ip_next = (io_seq_evt && !io_seq_kind) ? instr_addr : last_io_ip_reg;
        // only control and I/O checks reset the channel; the processor is left alone
        io_reset_next = ctrl_evt || io_fault_evt;
    end
    assign r7_wr = (class_next == CLS_PROGRAM);

    // status copy and level block load sequencer
    always_comb begin
        state_next = state_reg;
        copy_addr_next = copy_addr_reg;
        base_next = base_reg;
        level_next = level_reg;
        idx_next = idx_reg;
        ext_wr = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (copy_status_and_clear_instr) begin
                    copy_addr_next = copy_addr;
                    state_next = ST_COPY;
                end else if (load_level_block_instr) begin
                    base_next = block_addr;
                    level_next = block_level;
                    idx_next = 4'h0;
                    state_next = ST_READ;
                end
            end
            ST_COPY: if (mem_ready) state_next = ST_IDLE;
            ST_READ: if (mem_ready) state_next = ST_WAIT;
            ST_WAIT: begin
                ext_wr = 1'b1;
                if (idx_reg == 4'(LSB_WORDS - 1)) begin
                    state_next = ST_IDLE;
                end else begin
                    idx_next = idx_reg + 4'h1;
                    state_next = ST_READ;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            status_reg <= STATUS_RESET;
            class_reg <= CLS_NONE;
            saved_reg <= 16'h0000;
            save_reg <= 1'b0;
            io_reset_reg <= 1'b0;
            copy_addr_reg <= 16'h0000;
            base_reg <= 16'h0000;
            level_reg <= 2'h0;
            idx_reg <= 4'h0;
            last_io_ip_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            status_reg <= status_next;
            class_reg <= class_next;
            saved_reg <= saved_next;
            save_reg <= save_next;
            io_reset_reg <= io_reset_next;
            copy_addr_reg <= copy_addr_next;
            base_reg <= base_next;
            level_reg <= level_next;
            idx_reg <= idx_next;
            last_io_ip_reg <= last_io_ip_next;
        end
    end

    assign mem_req = (state_reg == ST_COPY) || (state_reg == ST_READ);
    assign mem_we = (state_reg == ST_COPY);
    assign mem_addr = (state_reg == ST_COPY) ? copy_addr_reg : base_reg + {12'h000, idx_reg};
    assign mem_wdata = (state_reg == ST_COPY) ? status_reg : 16'h0000;
    assign processor_error_status = status_reg;
    assign class_irq = class_reg;
    assign saved_ip = saved_reg;
    assign save_block = save_reg;
    assign io_reset = io_reset_reg;
    assign busy = (state_reg != ST_IDLE);
    assign sel_level_lsr = lsr_active;
    assign sel_level_ip = saved_reg;
endmodule

// ---- hdl/err_status_pkg.sv ----
// Purpose: shared constants and types for the processor error status unit
// Assumes: 16-bit words, four priority levels, eight general registers per level
// Notes: bit numbers count from the most significant bit, bit 00 is [15]
package err_status_pkg;
    localparam int WORD_W = 16;
    localparam int LEVELS = 4;
    localparam int GREGS = 8;
    localparam int LSB_WORDS = 11;
    // status word bit numbers, msb-first
    localparam int BIT_SPEC = 0;
    localparam int BIT_ADDR = 1;
    localparam int BIT_PRIV = 2;
    localparam int BIT_FUNC = 4;
    localparam int BIT_STACK = 6;
    localparam int BIT_PARITY = 8;
    localparam int BIT_CTRL = 10;
    localparam int BIT_IOCHK = 11;
    localparam int BIT_SEQ = 12;
    localparam int BIT_AUTOLOAD = 13;
    localparam int BIT_PWR = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // mask of implemented bits; unused positions 03 05 07 09 14 are zero
    localparam logic [15:0] STATUS_USED = 16'hEABD;
    localparam logic [15:0] STATUS_EVENT_BITS = 16'hEAB1;
    // level status register fields, msb-first
    localparam int LSR_SUPV = 8;
    localparam int LSR_INPROC = 9;
    localparam int LSR_SMASK = 11;
    // storage layout of a level status block (word offsets)
    localparam logic [3:0] LSB_OFF_IAR = 4'h0;
    localparam logic [3:0] LSB_OFF_LSR = 4'h2;
    localparam logic [3:0] LSB_OFF_GR0 = 4'h3;
    localparam logic [4:0] OP_ILL_A = 5'h07;
    localparam logic [4:0] OP_ILL_B = 5'h16;
    localparam logic [4:0] OP_ILL_C = 5'h1B;
    localparam logic [4:0] OP_RSV = 5'h04;
    localparam logic [4:0] OP_08 = 5'h08;
    localparam logic [4:0] OP_0B = 5'h0B;
    localparam logic [4:0] OP_0C = 5'h0C;
    localparam logic [4:0] OP_0E = 5'h0E;
    localparam logic [4:0] OP_0F = 5'h0F;
    localparam logic [4:0] OP_1D = 5'h1D;
    typedef enum logic [3:0] {
        CLS_NONE = 4'h0,
        CLS_MACHINE = 4'h1,
        CLS_PROGRAM = 4'h2,
        CLS_SOFT = 4'h4,
        CLS_POWER = 4'h8
    } class_e;
    function automatic int pos(input int b);
        return 15 - b;
    endfunction
endpackage

// ---- hdl/lsb_bus_if.sv ----
// Purpose: storage word transfer between the sequencer core and the block loader
// Assumes: one word per cycle, valid-only handshake
// Notes: the core masters, the loader receives
interface lsb_bus_if;
    logic wr;
    logic [3:0] idx;
    logic [15:0] data;
    modport core(output wr, output idx, output data);
    modport loader(input wr, input idx, input data);
endinterface

// ---- hdl/opcode_checker.sv ----
// Purpose: classify an opcode/function pair as illegal or reserved
// Assumes: function field up to five bits, low bits used for narrower codes
// Notes: purely combinational
module opcode_checker
    import err_status_pkg::*;
(
    input wire logic [4:0] opcode, // instruction op field
    input wire logic [4:0] func, // function field
    input wire logic supv, // supervisor state
    output logic illegal, // program check class
    output logic reserved // soft trap class
);
    logic [3:0] f4;
    always_comb begin
        f4 = func[3:0];
        illegal = 1'b0;
        reserved = 1'b0;
        unique case (opcode)
            OP_ILL_A, OP_ILL_B, OP_ILL_C: illegal = 1'b1;
            OP_RSV: reserved = 1'b1;
            OP_08: illegal = (f4[3] == 1'b0) && (f4[2:0] != 3'h0) && (f4[2:0] != 3'h4);
            OP_0B: begin
                illegal = (f4 == 4'h5) || (f4 == 4'h7) || (supv && ((f4 == 4'h1) || (f4 == 4'h9)));
                reserved = supv && ((f4 == 4'h3) || (f4 == 4'hB));
            end
            OP_0C: illegal = (func[2:0] == 3'h7);
            OP_0E: illegal = (func == 5'h18) || (func == 5'h1A) || (func == 5'h1B) || (func == 5'h1C)
                || (func == 5'h1E) || (func == 5'h1F);
            OP_0F: illegal = (func[4] && func[2]) || (func[4:3] == 2'h1) || (func[4] && func[2:0] == 3'h3)
                || (func == 5'h11);
            OP_1D: illegal = (f4[3:2] == 2'h3);
            default: ;
        endcase
    end
endmodule

// ---- hdl/level_block_store.sv ----
// Purpose: hardware level status blocks for all priority levels
// Assumes: loaded one word at a time from storage by the core
// Notes: a level has instruction pointer, level state and eight general registers
module level_block_store
    import err_status_pkg::*;
(
    input wire logic clock, // processor clock
    input wire logic arst_n, // async reset
    lsb_bus_if.loader bus, // block words from storage
    input wire logic [1:0] sel_level, // level being loaded
    input wire logic r7_wr, // force general register seven
    input wire logic [1:0] r7_level, // level of that write
    input wire logic [15:0] r7_data, // storage pointer value
    input wire logic [1:0] rd_level, // level to display
    output logic [15:0] ip_out, // instruction pointer of rd_level
    output logic [15:0] lsr_out, // level state of rd_level
    output logic [15:0] r7_out // general register seven of rd_level
);
    logic [15:0] ip_reg [LEVELS];
    logic [15:0] lsr_reg [LEVELS];
    logic [15:0] gr_reg [LEVELS][GREGS];
    logic [15:0] ip_next [LEVELS];
    logic [15:0] lsr_next [LEVELS];
    logic [15:0] gr_next [LEVELS][GREGS];
    always_comb begin
        ip_next = ip_reg;
        lsr_next = lsr_reg;
        gr_next = gr_reg;
        if (bus.wr) begin
            if (bus.idx == LSB_OFF_IAR) ip_next[sel_level] = bus.data;
            else if (bus.idx == LSB_OFF_LSR) lsr_next[sel_level] = bus.data;
            else if (bus.idx >= LSB_OFF_GR0) gr_next[sel_level][3'(bus.idx - LSB_OFF_GR0)] = bus.data;
        end
        if (r7_wr) gr_next[r7_level][GREGS-1] = r7_data;
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int l = 0; l < LEVELS; l++) begin
                ip_reg[l] <= 16'h0000;
                lsr_reg[l] <= 16'h0000;
                for (int g = 0; g < GREGS; g++) gr_reg[l][g] <= 16'h0000;
            end
        end else begin
            ip_reg <= ip_next;
            lsr_reg <= lsr_next;
            gr_reg <= gr_next;
        end
    end
    assign ip_out = ip_reg[rd_level];
    assign lsr_out = lsr_reg[rd_level];
    assign r7_out = gr_reg[rd_level][GREGS-1];
endmodule

// ---- bench/storage_model.sv ----
// Purpose: storage port model for the error status unit
// Assumes: read data follows an accepted read by one cycle
// Notes: slow mode accepts on alternate cycles; idle data toggles
module storage_model (
    input wire logic clock, // clock
    input wire logic arst_n, // reset
    input wire logic slow, // slow accept
    input wire logic mem_req, // request
    input wire logic mem_we, // write
    input wire logic [15:0] mem_addr, // address
    output logic mem_ready, // accept
    output logic [15:0] mem_rdata // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog;
    logic hit_q;
    logic [15:0] dat_q;
    assign mem_ready = mem_req && (!slow || tog);
    assign mem_rdata = hit_q ? dat_q : ~dat_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tog <= 1'b0;
            hit_q <= 1'b0;
            dat_q <= 16'h0000;
        end else begin
            tog <= !tog;
            hit_q <= mem_ready && !mem_we;
            dat_q <= (mem_ready && !mem_we) ? {mem_addr[7:0], 8'h90} : mem_rdata;
        end
    end
endmodule

// ---- bench/processor_error_status_unit_chk.sv ----
// Purpose: port assertions for the error status unit
// Assumes: one clock, async low reset
// Notes: bound from the bench top file
module processor_error_status_unit_chk
    import err_status_pkg::*;
(
    input wire logic clock, // clock
    input wire logic arst_n, // reset
    input wire logic exec_valid, // decode
    input wire logic level_active, // level on
    input wire logic misalign_evt, // event
    input wire logic bad_addr_evt, // event
    input wire logic stack_evt, // event
    input wire logic parity_evt, // event
    input wire logic ctrl_fault_evt, // event
    input wire logic io_fault_evt, // event
    input wire logic io_seq_evt, // event
    input wire logic io_seq_kind, // kind
    input wire logic autoload_evt, // event
    input wire logic [15:0] processor_error_status, // status
    input wire logic [3:0] class_irq, // class
    input wire logic save_block, // save
    input wire logic io_reset // reset out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    logic [15:0] st;
    assign st = processor_error_status;
    AST_UNUSED_ZERO: assert property ((st & ~STATUS_USED) == 16'h0000)
        else $error("unused bits set");
    AST_PARITY: assert property (parity_evt |=> st[7] && class_irq == CLS_MACHINE)
        else $error("parity check missed");
    AST_CTRL: assert property (ctrl_fault_evt |=> st[5] && io_reset && class_irq == CLS_MACHINE)
        else $error("control check missed");
    AST_IOCHK: assert property (io_fault_evt |=> st[4] && io_reset && class_irq == CLS_MACHINE)
        else $error("io check missed");
    AST_NO_LEVEL: assert property (exec_valid && !level_active |=> st[5] && class_irq == CLS_MACHINE)
        else $error("no level check missed");
    AST_SEQ: assert property (io_seq_evt |=> st[3] == $past(io_seq_kind))
        else $error("sequence bit wrong");
    AST_SPEC: assert property (misalign_evt |=> st[15])
        else $error("alignment bit missed");
    AST_BAD_ADDR: assert property (bad_addr_evt |=> st[14])
        else $error("address bit missed");
    AST_STACK: assert property (stack_evt |=> st[9])
        else $error("stack bit missed");
    AST_AUTOLOAD: assert property (autoload_evt |=> st[2])
        else $error("autoload bit missed");
    AST_CLASS: assert property ($onehot0(class_irq) && save_block == (class_irq != 4'h0))
        else $error("class output bad");
    AST_IO_RESET: assert property (io_reset |-> $past(ctrl_fault_evt || io_fault_evt || (exec_valid && !level_active)))
        else $error("io reset without cause");
endmodule

// ---- bench/processor_error_status_unit_tb.sv ----
// Purpose: self-checking bench for the error status unit
// Assumes: 50 MHz clock, storage model on the storage port
// Notes: driver queues expected classes and writes, a monitor pops them
`define CHK(n, e, g) begin xe = 16'(e); xg = 16'(g); samples_checked++; if (xg !== xe) fail(n); end
module processor_error_status_unit_tb import err_status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, arst_n = 1'b0, exec_valid = 1'b0, privileged = 1'b0, level_active = 1'b1;
    logic io_seq_evt = 1'b0, io_seq_kind = 1'b0, autoload_evt = 1'b0, power_warn = 1'b0;
    logic cpy = 1'b0, ld = 1'b0, slow = 1'b0, mem_req, mem_we, mem_ready, save_block, io_reset, busy;
    logic [4:0] opcode = 5'h00, func = 5'h00;
    logic [5:0] ev = 6'h00;
    logic [3:0] class_irq;
    logic [15:0] instr_addr = 16'h0000, spr = 16'h0000, copy_addr = 16'h0000, block_addr = 16'h0000;
    logic [15:0] xe, xg, st, exp_st, saved_ip, level_state_reg, mem_addr, mem_wdata, mem_rdata, sip;
    logic [15:0] io_a = 16'h0000;
    logic [31:0] rs = 32'h000121AC;
    int mismatches = 0, samples_checked = 0, cycles = 0, resets = 0;
    logic [3:0] cls_q[$];
    logic [15:0] wa_q[$], wd_q[$];
    class_e ev_cls[6] = '{CLS_PROGRAM, CLS_PROGRAM, CLS_SOFT, CLS_MACHINE, CLS_MACHINE, CLS_MACHINE};
    int ev_bit[6] = '{BIT_SPEC, BIT_ADDR, BIT_STACK, BIT_PARITY, BIT_CTRL, BIT_IOCHK};
    always #10 clock = ~clock;
    processor_error_status_unit dut_u (
        .clock, .arst_n, .exec_valid, .opcode, .func, .privileged, .instr_addr, .storage_pointer_reg(spr),
        .active_level(2'h1), .level_active, .misalign_evt(ev[0]), .bad_addr_evt(ev[1]), .stack_evt(ev[2]),
        .parity_evt(ev[3]), .ctrl_fault_evt(ev[4]), .io_fault_evt(ev[5]), .io_seq_evt, .io_seq_kind,
        .autoload_evt, .power_warn, .copy_status_and_clear_instr(cpy), .copy_addr, .load_level_block_instr(ld),
        .block_addr, .block_level(2'h1), .mem_ready, .mem_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .processor_error_status(st), .class_irq, .saved_ip, .save_block, .io_reset, .busy,
        .sel_level_lsr(level_state_reg), .sel_level_ip(sip));
    storage_model mem_u (.clock, .arst_n, .slow, .mem_req, .mem_we, .mem_addr, .mem_ready, .mem_rdata);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic fail(input string n);
        mismatches++;
        $display("[ERR] %s expected %h seen %h", n, xe, xg);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_idle;
        int n = 0;
        tick(1);
        while (busy !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
        `CHK("busy", 1'b0, busy)
    endtask
    // k: 0..5 event pulse, 6 instruction, 7 io sequence, 8 autoload, 9 instruction with no level
    task automatic hit(input int k, input logic [4:0] op, fn, input logic pv, input logic [3:0] c, input int b);
        logic [15:0] a;
        rs = xs(rs);
        a = rs[15:0];
        @(posedge clock);
        instr_addr <= a;
        spr <= rs[31:16];
        if (k < 6) ev <= 6'(1 << k);
        exec_valid <= (k == 6 || k == 9);
        level_active <= (k != 9);
        opcode <= op;
        func <= fn;
        privileged <= pv && k == 6;
        io_seq_evt <= (k == 7);
        io_seq_kind <= pv;
        autoload_evt <= (k == 8);
        if (c !== 4'h0) cls_q.push_back(c);
        if (k == 7) exp_st[15 - BIT_SEQ] = pv;
        else if (b >= 0) exp_st[15 - b] = 1'b1;
        @(posedge clock);
        ev <= 6'h00;
        exec_valid <= 1'b0;
        level_active <= 1'b1;
        io_seq_evt <= 1'b0;
        autoload_evt <= 1'b0;
        tick(2);
        `CHK("status", exp_st, st)
        if (c == CLS_PROGRAM || c == CLS_SOFT || (k == 5 && !exp_st[15 - BIT_SEQ])) begin
            `CHK("saved_ip", (k == 5) ? io_a : a, saved_ip)
            `CHK("sel_level_ip", (k == 5) ? io_a : a, sip)
        end
        // a program-issued sequence names the instruction an I/O check reports
        if (k == 7 && !pv) io_a = a;
    endtask
    task automatic copy_status;
        @(posedge clock);
        cpy <= 1'b1;
        copy_addr <= rs[15:0];
        wa_q.push_back(rs[15:0]);
        wd_q.push_back(exp_st);
        @(posedge clock);
        cpy <= 1'b0;
        wait_idle();
        exp_st = exp_st & ~STATUS_EVENT_BITS;
        `CHK("status_cleared", exp_st, st)
    endtask
    task automatic load_block(input logic [15:0] base);
        @(posedge clock);
        ld <= 1'b1;
        block_addr <= base;
        @(posedge clock);
        ld <= 1'b0;
        wait_idle();
        `CHK("level_state", {8'(base[7:0] + 8'h02), 8'h90}, level_state_reg)
    endtask
    // monitor: every class pulse and storage write consumes the oldest note
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
        if (arst_n && class_irq !== 4'h0) `CHK("class_irq", cls_q.size() ? cls_q.pop_front() : 4'h0, class_irq)
        if (arst_n && io_reset === 1'b1) resets++;
        if (arst_n && mem_req && mem_we && mem_ready) begin
            `CHK("write_addr", wa_q.size() ? wa_q.pop_front() : 16'h0000, mem_addr)
            `CHK("write_data", wd_q.size() ? wd_q.pop_front() : 16'h0000, mem_wdata)
        end
    end
    initial begin
        exp_st = STATUS_RESET;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        tick(2);
        `CHK("reset_status", STATUS_RESET, st)
        for (int i = 0; i < 6; i++) hit(i, 5'h00, 5'h00, 1'b0, ev_cls[i], ev_bit[i]);
        `CHK("io_resets", 2, resets)
        copy_status();
        $display("test events done");
        hit(6, OP_ILL_A, rs[4:0], 1'b0, CLS_PROGRAM, BIT_FUNC);
        hit(6, OP_ILL_B, rs[4:0], 1'b0, CLS_PROGRAM, BIT_FUNC);
        hit(6, OP_ILL_C, rs[4:0], 1'b0, CLS_PROGRAM, BIT_FUNC);
        hit(6, OP_08, 5'h01, 1'b0, CLS_PROGRAM, BIT_FUNC);
        hit(6, OP_1D, 5'h0C, 1'b0, CLS_PROGRAM, BIT_FUNC);
        hit(6, OP_RSV, rs[4:0], 1'b0, CLS_SOFT, BIT_FUNC);
        hit(6, OP_0B, 5'h03, 1'b0, CLS_NONE, -1);
        hit(6, 5'h00, 5'h00, 1'b1, CLS_PROGRAM, BIT_PRIV);
        hit(7, 5'h00, 5'h00, 1'b1, CLS_NONE, -1);
        hit(7, 5'h00, 5'h00, 1'b0, CLS_NONE, -1);
        hit(5, 5'h00, 5'h00, 1'b0, CLS_MACHINE, BIT_IOCHK);
        hit(8, 5'h00, 5'h00, 1'b0, CLS_NONE, BIT_AUTOLOAD);
        copy_status();
        $display("test instructions done");
        slow <= 1'b1;
        load_block(rs[15:0]);
        slow <= 1'b0;
        hit(6, OP_0B, 5'h0B, 1'b0, CLS_SOFT, BIT_FUNC);
        hit(9, 5'h00, 5'h00, 1'b0, CLS_MACHINE, BIT_CTRL);
        `CHK("io_resets", 4, resets)
        copy_status();
        $display("test level block done");
        @(posedge clock);
        power_warn <= 1'b1;
        cls_q.push_back(CLS_POWER);
        exp_st[15 - BIT_PWR] = 1'b1;
        tick(8);
        `CHK("power_status", exp_st, st)
        `CHK("queues_left", 0, cls_q.size() + wa_q.size())
        $display("test power done");
        end_of_test();
    end
endmodule
bind processor_error_status_unit processor_error_status_unit_chk chk_u (
    .clock, .arst_n, .exec_valid, .level_active, .misalign_evt, .bad_addr_evt, .stack_evt, .parity_evt,
    .ctrl_fault_evt, .io_fault_evt, .io_seq_evt, .io_seq_kind, .autoload_evt, .processor_error_status,
    .class_irq, .save_block, .io_reset);
